//--- shared/rsf_cfg.svh
/*
  Constants of the rotate, subtract and flag execution unit.
  Assumes inclusion by bare name from the package and the testbench.
*/
`ifndef RSF_CFG_SVH
`define RSF_CFG_SVH
// Opcodes served by the unit.
`define OP_CLR_CARRY 8'hCF
`define OP_SUB_EXIT  8'hAF
`define OP_RL_R      8'h90
`define OP_RL_IR     8'h91
`define OP_RLC_R     8'h10
`define OP_RLC_IR    8'h11
`define OP_RR_R      8'hE0
`define OP_RR_IR     8'hE1
`define OP_RRC_R     8'hC0
`define OP_RRC_IR    8'hC1
`define OP_BANK0     8'h4F
`define OP_BANK1     8'h5F
`define OP_SBC_RR    8'h32
`define OP_SBC_RIR   8'h33
`define OP_SBC_GG    8'h34
`define OP_SBC_GIR   8'h35
`define OP_SBC_IM    8'h36
// Cycle counts per instruction.
`define CYC_SHORT    4'h4
`define CYC_LONG     4'h6
`define CYC_EXIT     4'h8
// Flag bit positions in the condition code register.
`define FLG_C        7
`define FLG_Z        6
`define FLG_S        5
`define FLG_V        4
`define FLG_D        3
`define FLG_H        2
`define FLG_BANK     0
// Register file locations.
`define FLAGS_ADDR   8'hD5
`define SP_HI_ADDR   8'hD8
`define SP_LO_ADDR   8'hD9
`define WORK_BASE    4'hC
`define SP_STEP      16'h0002
`define PC_RESET     16'h0000
`endif

//--- shared/rsf_pkg.sv
/*
  Types of the rotate, subtract and flag execution unit.
  Assumes rsf_cfg.svh sits on the include path.
*/
package rsf_pkg;
  `include "rsf_cfg.svh"
  // Sequencer states.
  typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_EXEC, ST_WAIT} rsf_state_t;
endpackage

//--- core/rsf_exec.sv
/*
  Execution unit for carry clear, subroutine exit, four rotates, bank
  select and subtract with borrow, with its own 256-byte register file.
  Assumes a decoder that pulses instr_start with opcode and operand bytes
  and a master on the plain register port; one clock, async low reset.
*/
// The address map and the plain strobed port were decided locally.
// Behaviour
// - Clear carry zeroes carry, keeps other flags.
// - Exit pops counter, stack pointer plus two.
// - Rotate left copies bit 7 to bit0, carry.
// - Rotate left overflow flag on sign change.
// - Left through carry: bit7 to carry, carry in.
// - Rotate right copies bit 0 to bit7, carry.
// - Right through carry: bit0 to carry, carry in.
// - Overflow equals sign change across rotation.
// - Rotates set zero, sign; keep decimal, half.
// - Bank zero instruction clears flag bit 0.
// - Bank one instruction sets flag bit 0.
// - Subtract with borrow, register form, four cycles.
// - Other subtract forms decoded, six cycles each.
// - Subtract sets carry, zero, sign flags.
// - Subtract overflow from operand and result signs.
// - Subtract sets decimal, half from low nibble.
// - Stack pointer bytes held at D8, D9.
`timescale 1ns/1ps
module rsf_exec
  import rsf_pkg::*;
#(
  parameter int AW = 8
)(
  input  wire logic        sys_clk,      // Core clock, 25 MHz.
  input  wire logic        nrst,         // Asynchronous reset, active low.
  input  wire logic        instr_start,  // One-cycle start pulse.
  input  wire logic [7:0]  instr_op,     // Opcode.
  input  wire logic [7:0]  instr_b1,     // First operand byte.
  input  wire logic [7:0]  instr_b2,     // Second operand byte.
  input  wire logic [7:0]  bus_addr,     // Register file address.
  input  wire logic [7:0]  bus_wdata,    // Write data.
  input  wire logic        bus_wr,       // Write strobe.
  input  wire logic        bus_rd,       // Read strobe.
  output logic      [7:0]  bus_rdata,    // Read data, cycle after strobe.
  output logic             exec_busy,    // Instruction in progress.
  output logic             exec_done,    // One-cycle end pulse.
  output logic             exec_illegal, // Done pulse was unknown opcode.
  output logic      [15:0] program_counter, // Fetch address.
  output logic             bank_sel      // Bank flag copy.
);
  initial begin
    if (AW != 8) $error("rsf_exec serves an 8-bit register address only");
  end

  // Cycle count of a served opcode, zero when unknown.
  function automatic logic [3:0] cycles_of(input logic [7:0] op);
    case (op)
      `OP_SUB_EXIT: cycles_of = `CYC_EXIT;
      `OP_SBC_RIR, `OP_SBC_GG, `OP_SBC_GIR, `OP_SBC_IM: cycles_of = `CYC_LONG;
      `OP_CLR_CARRY, `OP_BANK0, `OP_BANK1, `OP_SBC_RR,
      `OP_RL_R, `OP_RL_IR, `OP_RLC_R, `OP_RLC_IR,
      `OP_RR_R, `OP_RR_IR, `OP_RRC_R, `OP_RRC_IR: cycles_of = `CYC_SHORT;
      default: cycles_of = 4'h0;
    endcase
  endfunction

  // Instruction length in bytes, used to step the fetch address.
  function automatic logic [15:0] len_of(input logic [7:0] op);
    case (op)
      `OP_CLR_CARRY, `OP_BANK0, `OP_BANK1: len_of = 16'h0001;
      `OP_SBC_GG, `OP_SBC_GIR, `OP_SBC_IM: len_of = 16'h0003;
      default: len_of = 16'h0002;
    endcase
  endfunction

  // Working register nibble to register file address.
  function automatic logic [7:0] wreg(input logic [3:0] n);
    wreg = {`WORK_BASE, n};
  endfunction

  rsf_state_t  state_q, state_d;
  logic [3:0]  cnt_q, cnt_d, cyc_q, cyc_d;
  logic [7:0]  op_q, op_d, b1_q, b1_d, b2_q, b2_d;
  logic [7:0]  dst_q, dst_d, src_q, src_d;
  logic [15:0] pc_q, pc_d;
  logic        done_q, done_d, ill_q, ill_d, busy_q, busy_d;
  logic [7:0]  rdata_q, rdata_d;
  logic        bank_q, bank_d;
  logic [7:0]  rf_q [256];
  logic [7:0]  rf_d [256];
  // Core write requests raised in the execute cycle.
  logic        wr_dst, wr_flg, wr_sp;
  logic [7:0]  res, flg, dval, sval;
  logic [15:0] sp_now, sp_new;
  logic [8:0]  diff;
  logic [4:0]  lo;

  assign sp_now = {rf_q[`SP_HI_ADDR], rf_q[`SP_LO_ADDR]};
  assign dval   = rf_q[dst_q];
  assign sval   = (op_q == `OP_SBC_IM) ? b2_q : rf_q[src_q];

  // Sequencer, operand addressing and execution results.
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q + 4'h1;
    cyc_d   = cyc_q;
    op_d    = op_q;
    b1_d    = b1_q;
    b2_d    = b2_q;
    dst_d   = dst_q;
    src_d   = src_q;
    pc_d    = pc_q;
    done_d  = 1'b0;
    ill_d   = ill_q;
    wr_dst  = 1'b0;
    wr_flg  = 1'b0;
    wr_sp   = 1'b0;
    res     = dval;
    flg     = rf_q[`FLAGS_ADDR];
    sp_new  = sp_now + `SP_STEP;
    diff    = {1'b0, dval} - {1'b0, sval} - {8'h00, flg[`FLG_C]};
    lo      = {1'b0, dval[3:0]} + {1'b0, ~sval[3:0]} + {4'h0, ~flg[`FLG_C]};
    case (state_q)
      ST_IDLE: begin
        cnt_d = 4'h1;
        if (instr_start) begin
          op_d  = instr_op;
          b1_d  = instr_b1;
          b2_d  = instr_b2;
          cyc_d = cycles_of(instr_op);
          if (cycles_of(instr_op) == 4'h0) begin
            done_d = 1'b1;
            ill_d  = 1'b1;
          end else begin
            ill_d   = 1'b0;
            state_d = ST_ADDR;
          end
        end
      end
      ST_ADDR: begin
        state_d = ST_EXEC;
        dst_d   = b1_q;
        src_d   = b2_q;
        case (op_q)
          `OP_SBC_RR: begin
            dst_d = wreg(b1_q[7:4]);
            src_d = wreg(b1_q[3:0]);
          end
          `OP_SBC_RIR: begin
            dst_d = wreg(b1_q[7:4]);
            src_d = rf_q[wreg(b1_q[3:0])];
          end
          `OP_SBC_GG: begin
            src_d = b1_q;
            dst_d = b2_q;
          end
          `OP_SBC_GIR: begin
            src_d = rf_q[b1_q];
            dst_d = b2_q;
          end
          `OP_RL_IR, `OP_RLC_IR, `OP_RR_IR, `OP_RRC_IR: begin
            dst_d = rf_q[b1_q];
          end
          default: begin
            dst_d = b1_q;
          end
        endcase
      end
      ST_EXEC: begin
        state_d = ST_WAIT;
        pc_d    = pc_q + len_of(op_q);
        wr_flg  = 1'b1;
        case (op_q)
          `OP_CLR_CARRY: flg[`FLG_C] = 1'b0;
          `OP_BANK0: flg[`FLG_BANK] = 1'b0;
          `OP_BANK1: flg[`FLG_BANK] = 1'b1;
          `OP_SUB_EXIT: begin
            wr_flg = 1'b0;
            wr_sp  = 1'b1;
            pc_d   = {rf_q[sp_now[7:0]], rf_q[sp_now[7:0] + 8'h01]};
          end
          `OP_SBC_RR, `OP_SBC_RIR, `OP_SBC_GG, `OP_SBC_GIR, `OP_SBC_IM: begin
            wr_dst     = 1'b1;
            res        = diff[7:0];
            flg[`FLG_C] = diff[8];
            flg[`FLG_Z] = (diff[7:0] == 8'h00);
            flg[`FLG_S] = diff[7];
            flg[`FLG_V] = (dval[7] ^ sval[7]) & (diff[7] == sval[7]);
            flg[`FLG_D] = 1'b1;
            flg[`FLG_H] = ~lo[4];
          end
          default: begin
            wr_dst = 1'b1;
            case (op_q)
              `OP_RL_R, `OP_RL_IR: res = {dval[6:0], dval[7]};
              `OP_RLC_R, `OP_RLC_IR: res = {dval[6:0], flg[`FLG_C]};
              `OP_RR_R, `OP_RR_IR: res = {dval[0], dval[7:1]};
              default: res = {flg[`FLG_C], dval[7:1]};
            endcase
            flg[`FLG_C] = op_q[6] ? dval[0] : dval[7];
            flg[`FLG_Z] = (res == 8'h00);
            flg[`FLG_S] = res[7];
            flg[`FLG_V] = dval[7] ^ res[7];
          end
        endcase
      end
      ST_WAIT: begin
        if (cnt_q == cyc_q - 4'h1) begin
          state_d = ST_IDLE;
          done_d  = 1'b1;
        end
      end
      default: state_d = ST_IDLE;
    endcase
    busy_d = (state_d != ST_IDLE);
  end

  // Register file next value: bus write first, core writes override.
  always_comb begin
    rf_d = rf_q;
    rdata_d = bus_rd ? rf_q[bus_addr] : 8'h00;
    if (bus_wr) begin
      rf_d[bus_addr] = bus_wdata;
    end
    if (wr_dst) begin
      rf_d[dst_q] = res;
    end
    if (wr_flg) begin
      rf_d[`FLAGS_ADDR] = flg;
    end
    if (wr_sp) begin
      rf_d[`SP_HI_ADDR] = sp_new[15:8];
      rf_d[`SP_LO_ADDR] = sp_new[7:0];
    end
    bank_d = rf_d[`FLAGS_ADDR][`FLG_BANK];
  end

  // State registers.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
      cnt_q   <= 4'h0;
      cyc_q   <= 4'h0;
      op_q    <= 8'h00;
      b1_q    <= 8'h00;
      b2_q    <= 8'h00;
      dst_q   <= 8'h00;
      src_q   <= 8'h00;
      pc_q    <= `PC_RESET;
      done_q  <= 1'b0;
      ill_q   <= 1'b0;
      busy_q  <= 1'b0;
      rdata_q <= 8'h00;
      bank_q  <= 1'b0;
      for (int i = 0; i < 256; i++) begin
        rf_q[i] <= 8'h00;
      end
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      cyc_q   <= cyc_d;
      op_q    <= op_d;
      b1_q    <= b1_d;
      b2_q    <= b2_d;
      dst_q   <= dst_d;
      src_q   <= src_d;
      pc_q    <= pc_d;
      done_q  <= done_d;
      ill_q   <= ill_d;
      busy_q  <= busy_d;
      rdata_q <= rdata_d;
      bank_q  <= bank_d;
      rf_q    <= rf_d;
    end
  end

  // Outputs straight from their flip-flops.
  assign bus_rdata       = rdata_q;
  assign exec_busy       = busy_q;
  assign exec_done       = done_q;
  assign exec_illegal    = ill_q;
  assign program_counter = pc_q;
  assign bank_sel        = bank_q;

  // Checks on execution results.
  sequence s_exec(logic [7:0] op);
    state_q == ST_EXEC && op_q == op;
  endsequence
  property p_clr_carry;
    @(posedge sys_clk) disable iff (!nrst) s_exec(`OP_CLR_CARRY) |=>
      rf_q[`FLAGS_ADDR][`FLG_C] == 1'b0 &&
      rf_q[`FLAGS_ADDR][6:0] == $past(rf_q[`FLAGS_ADDR][6:0]);
  endproperty
  a_clr_carry: assert property (p_clr_carry) else $error("carry clear failed");
  property p_exit;
    @(posedge sys_clk) disable iff (!nrst) s_exec(`OP_SUB_EXIT) |=>
      pc_q == {$past(rf_q[sp_now[7:0]]), $past(rf_q[sp_now[7:0] + 8'h01])} &&
      sp_now == $past(sp_now) + `SP_STEP;
  endproperty
  a_exit: assert property (p_exit) else $error("subroutine exit wrong");
  property p_rl;
    @(posedge sys_clk) disable iff (!nrst) s_exec(`OP_RL_R) |=>
      rf_q[`FLAGS_ADDR][`FLG_C] == $past(dval[7]) && rf_q[`FLAGS_ADDR][`FLG_V] == $past(dval[7] ^ dval[6]);
  endproperty
  a_rl: assert property (p_rl) else $error("rotate left flags wrong");
  property p_rrc;
    @(posedge sys_clk) disable iff (!nrst) s_exec(`OP_RRC_R) |=>
      rf_q[`FLAGS_ADDR][`FLG_C] == $past(dval[0]) &&
      rf_q[$past(dst_q)][7] == $past(rf_q[`FLAGS_ADDR][`FLG_C]);
  endproperty
  a_rrc: assert property (p_rrc) else $error("rotate right through carry wrong");
  property p_rot_zero;
    @(posedge sys_clk) disable iff (!nrst) s_exec(`OP_RR_R) |=>
      rf_q[`FLAGS_ADDR][`FLG_Z] == (rf_q[$past(dst_q)] == 8'h00) &&
      rf_q[`FLAGS_ADDR][3:2] == $past(rf_q[`FLAGS_ADDR][3:2]);
  endproperty
  a_rot_zero: assert property (p_rot_zero) else $error("rotate zero flag wrong");
  property p_bank0;
    @(posedge sys_clk) disable iff (!nrst) s_exec(`OP_BANK0) |=> ##1 bank_sel == 1'b0;
  endproperty
  a_bank0: assert property (p_bank0) else $error("bank zero not selected");
  property p_bank1;
    @(posedge sys_clk) disable iff (!nrst) s_exec(`OP_BANK1) |=> rf_q[`FLAGS_ADDR][`FLG_BANK];
  endproperty
  a_bank1: assert property (p_bank1) else $error("bank one not selected");
  property p_sbc_time;
    @(posedge sys_clk) disable iff (!nrst)
      state_q == ST_IDLE && instr_start && instr_op == `OP_SBC_RR |=> !exec_done [*3] ##1 exec_done;
  endproperty
  a_sbc_time: assert property (p_sbc_time) else $error("register subtract not four cycles");
  property p_sbc_long;
    @(posedge sys_clk) disable iff (!nrst)
      state_q == ST_IDLE && instr_start && instr_op == `OP_SBC_IM |-> ##6 exec_done;
  endproperty
  a_sbc_long: assert property (p_sbc_long) else $error("immediate subtract not six cycles");
  property p_sbc_flags;
    @(posedge sys_clk) disable iff (!nrst) s_exec(`OP_SBC_GG) |=>
      rf_q[`FLAGS_ADDR][`FLG_D] && rf_q[`FLAGS_ADDR][`FLG_C] == $past(diff[8]) &&
      rf_q[`FLAGS_ADDR][`FLG_Z] == (rf_q[$past(dst_q)] == 8'h00);
  endproperty
  a_sbc_flags: assert property (p_sbc_flags) else $error("subtract flags wrong");
endmodule // rsf_exec

//--- testbench/tb_top.sv
/*
  Self-checking bench of the rotate, subtract and flag execution unit.
  Assumes rsf_pkg and rsf_exec are compiled first and rsf_cfg.svh is on the include path.
*/
`timescale 1ns/1ps
`include "rsf_cfg.svh"
module tb_top;
  import rsf_pkg::*;
  logic        sys_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        instr_start = 1'b0;
  logic [7:0]  instr_op = 8'h00, instr_b1 = 8'h00, instr_b2 = 8'h00;
  logic [7:0]  bus_addr = 8'h00, bus_wdata = 8'h00;
  logic        bus_wr = 1'b0, bus_rd = 1'b0, rd_seen = 1'b0;
  logic [7:0]  bus_rdata;
  logic        exec_busy, exec_done, exec_illegal, bank_sel;
  logic [15:0] program_counter;
  logic [15:0] pc_x = 16'h0000;
  int          n_fail = 0;
  int          checks_done = 0;
  logic [7:0]  exp_q[$];
  string       name_q[$];
  logic [7:0]  op, v, f, d, s, da, b1, b2, r;
  logic [8:0]  r9;
  logic [4:0]  h5;

  rsf_exec #(.AW(8)) rsf_exec_inst (.sys_clk(sys_clk), .nrst(nrst), .instr_start(instr_start),
    .instr_op(instr_op), .instr_b1(instr_b1), .instr_b2(instr_b2), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .exec_busy(exec_busy), .exec_done(exec_done), .exec_illegal(exec_illegal),
    .program_counter(program_counter), .bank_sel(bank_sel));

  // The clock toggles every half period of 20 ns.
  always #20 sys_clk = ~sys_clk;

  // Counts one comparison and reports a mismatch at once.
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Notes which edge carried a read strobe, so the answer cycle is known.
  always @(posedge sys_clk) rd_seen <= bus_rd;

  // Takes the oldest note off the queue when a read answer stands.
  always @(negedge sys_clk) begin
    if (rd_seen) begin
      if (exp_q.size() == 0) chk("read_queue", 16'h0001, 16'h0000);
      else chk(name_q.pop_front(), {8'h00, exp_q.pop_front()}, {8'h00, bus_rdata});
    end
  end

  // One-cycle register write.
  task automatic wr(logic [7:0] a, logic [7:0] w);
    @(posedge sys_clk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= w;
    @(posedge sys_clk);
    bus_wr <= 1'b0;
  endtask

  // One-cycle register read; the expected byte goes to the queue.
  task automatic rd(logic [7:0] a, logic [7:0] e, string nm);
    @(posedge sys_clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    exp_q.push_back(e);
    name_q.push_back(nm);
    @(posedge sys_clk);
    bus_rd <= 1'b0;
  endtask

  // Starts one instruction, checks its length in cycles, busy and the fetch address.
  task automatic run(logic [7:0] o, logic [7:0] p1, logic [7:0] p2, int n, int len);
    int k;
    @(posedge sys_clk);
    instr_start <= 1'b1;
    instr_op <= o;
    instr_b1 <= p1;
    instr_b2 <= p2;
    @(posedge sys_clk);
    instr_start <= 1'b0;
    for (k = 1; k < 20; k++) begin
      #1;
      if (exec_done === 1'b1) break;
      if (exec_busy !== 1'b1) chk("exec_busy", 16'h0001, {15'h0000, exec_busy});
      @(posedge sys_clk);
    end
    if (k == 20) begin
      chk("exec_done_wait", 16'h0001, 16'h0000);
      print_verdict();
    end else begin
      chk("cycles", 16'(n), 16'(k));
      pc_x = pc_x + 16'(len);
      chk("program_counter", pc_x, program_counter);
    end
  endtask

  // Reference rotate: returns the new carry above the 8-bit result.
  function automatic logic [8:0] rot(logic [7:0] o, logic [7:0] x, logic c);
    case (o[7:4])
      4'h9: return {x[7], x[6:0], x[7]};
      4'h1: return {x[7], x[6:0], c};
      4'hE: return {x[0], x[0], x[7:1]};
      default: return {x[0], c, x[7:1]};
    endcase
  endfunction

  // Main sequence: reset, rotates, subtract forms, carry, bank and exit.
  initial begin
    logic [7:0] rops [8];
    rops = '{`OP_RL_R, `OP_RL_IR, `OP_RLC_R, `OP_RLC_IR, `OP_RR_R, `OP_RR_IR, `OP_RRC_R, `OP_RRC_IR};
    void'($urandom(9));
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    rd(`FLAGS_ADDR, 8'h00, "flags_reset");
    chk("bank_reset", 16'h0000, {15'h0000, bank_sel});
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      op = rops[i];
      v = 8'($urandom);
      f = 8'($urandom) & 8'hFD;
      if (i == 2) begin
        v = 8'h80;
        f[7] = 1'b0;
      end
      wr(`FLAGS_ADDR, f);
      wr(8'h10, op[0] ? 8'h20 : v);
      if (op[0]) wr(8'h20, v);
      r9 = rot(op, v, f[7]);
      run(op, 8'h10, 8'h00, 4, 2);
      rd(op[0] ? 8'h20 : 8'h10, r9[7:0], "rot_result");
      rd(`FLAGS_ADDR, {r9[8], r9[7:0] == 8'h00, r9[7], v[7] ^ r9[7], f[3:0]}, "rot_flags");
    end
    $display("test rotates done");
    for (int i = 0; i < 5; i++) begin
      op = `OP_SBC_RR + 8'(i);
      d = 8'($urandom);
      s = 8'($urandom);
      f = 8'($urandom) & 8'hFD;
      if (i == 0) begin
        d = 8'h10;
        s = 8'h0F;
        f[7] = 1'b1;
      end
      wr(`FLAGS_ADDR, f);
      case (i)
        0: begin da = 8'hC1; wr(8'hC2, s); b1 = 8'h12; b2 = 8'h00; end
        1: begin da = 8'hC1; wr(8'hC2, 8'h30); wr(8'h30, s); b1 = 8'h12; b2 = 8'h00; end
        2: begin da = 8'h22; wr(8'h21, s); b1 = 8'h21; b2 = 8'h22; end
        3: begin da = 8'h22; wr(8'h21, 8'h30); wr(8'h30, s); b1 = 8'h21; b2 = 8'h22; end
        default: begin da = 8'h22; b1 = 8'h22; b2 = s; end
      endcase
      wr(da, d);
      run(op, b1, b2, i == 0 ? 4 : 6, i < 2 ? 2 : 3);
      r9 = {1'b0, d} - {1'b0, s} - {8'h00, f[7]};
      r = r9[7:0];
      h5 = {1'b0, d[3:0]} + {1'b0, ~s[3:0]} + {4'h0, ~f[7]};
      rd(da, r, "sbc_result");
      rd(`FLAGS_ADDR, {r9[8], r == 8'h00, r[7], (d[7] != s[7]) && (r[7] == s[7]), 1'b1, ~h5[4], f[1:0]},
         "sbc_flags");
      if (i == 2) rd(8'h21, s, "sbc_source");
    end
    $display("test subtract done");
    f = (8'($urandom) & 8'hFD) | 8'h80;
    wr(`FLAGS_ADDR, f);
    run(`OP_CLR_CARRY, 8'h00, 8'h00, 4, 1);
    rd(`FLAGS_ADDR, f & 8'h7F, "clear_carry_flags");
    run(`OP_BANK1, 8'h00, 8'h00, 4, 1);
    chk("bank_sel_one", 16'h0001, {15'h0000, bank_sel});
    rd(`FLAGS_ADDR, (f & 8'h7F) | 8'h01, "bank_one_flags");
    run(`OP_BANK0, 8'h00, 8'h00, 4, 1);
    chk("bank_sel_zero", 16'h0000, {15'h0000, bank_sel});
    rd(`FLAGS_ADDR, f & 8'h7E, "bank_zero_flags");
    run(8'hFF, 8'h00, 8'h00, 1, 0);
    chk("exec_illegal_set", 16'h0001, {15'h0000, exec_illegal});
    $display("test carry and bank done");
    wr(`SP_HI_ADDR, 8'h00);
    wr(`SP_LO_ADDR, 8'hFC);
    wr(8'hFC, 8'h10);
    wr(8'hFD, 8'h1A);
    pc_x = 16'h101A;
    run(`OP_SUB_EXIT, 8'h00, 8'h00, 8, 0);
    rd(`SP_LO_ADDR, 8'hFE, "stack_low");
    rd(`SP_HI_ADDR, 8'h00, "stack_high");
    rd(`FLAGS_ADDR, f & 8'h7E, "exit_flags");
    run(`OP_BANK1, 8'h00, 8'h00, 4, 1);
    chk("exec_illegal_clear", 16'h0000, {15'h0000, exec_illegal});
    $display("test exit done");
    repeat (2) @(posedge sys_clk);
    print_verdict();
  end
endmodule // tb_top
